// ---- pkg/irmf_defs.vh ----
// constants of the interrupt request and mask flag bank
`ifndef IRMF_DEFS_VH
`define IRMF_DEFS_VH

// ---------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------
`define IRMF_ADDR_W 16
`define IRMF_PEND_LOW_ADDR 16'hffe0
`define IRMF_PEND_HIGH_ADDR 16'hffe1
`define IRMF_MASK_LOW_ADDR 16'hffe4
`define IRMF_MASK_HIGH_ADDR 16'hffe5

// ---------------------------------------------------------------
// reset values and fixed bits
// ---------------------------------------------------------------
`define IRMF_PEND_RESET 8'h00
`define IRMF_MASK_RESET 8'hff
`define IRMF_PEND_HIGH_FIXED 5'h00
`define IRMF_MASK_HIGH_FIXED 5'h1f
`define IRMF_UNMAPPED_READ 8'h00
`define IRMF_WDT_MASK_UNDEF 1'b0
`define IRMF_BYTE_ALL 8'hff
`define IRMF_BYTE_ONE 8'h01

// ---------------------------------------------------------------
// source layout, index is also priority (0 highest)
// ---------------------------------------------------------------
`define IRMF_NUM_SRC 11
`define IRMF_IDX_W 4
`define IRMF_HIGH_BITS 3
`define IRMF_SRC_WDT 0
`define IRMF_SRC_PIN0 1
`define IRMF_SRC_PIN1 2
`define IRMF_SRC_TMD 3
`define IRMF_SRC_T0C0 4
`define IRMF_SRC_T0C1 5
`define IRMF_SRC_TM5 6
`define IRMF_SRC_SRX 7
`define IRMF_SRC_STX 8
`define IRMF_SRC_LVD 9
`define IRMF_SRC_NVW 10

`endif

// ---- hdl/irmf_priority_pick.v ----
// fixed priority picker, lowest index wins
`timescale 1ns/100ps

module irmf_priority_pick #(
    parameter N = 11,
    parameter IW = 4
) (
    // candidates
    input wire [N-1:0] ready,
    // choice
    output reg any,
    output reg [IW-1:0] index
);

    integer i;

    always @* begin
        any = 1'b0;
        index = {IW{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (ready[i]) begin
                any = 1'b1;
                index = i[IW-1:0];
            end
        end
    end

endmodule

// ---- hdl/irmf_flag_bank.v ----
// interrupt request flags, mask flags and request offer
`timescale 1ns/100ps
`include "irmf_defs.vh"

// Function
// RULE1 - each source has a pending flag, set by request or software one
// RULE2 - acknowledge clears the granted source's pending flag
// RULE3 - reset clears both pending registers to zero
// RULE4 - reset sets both mask registers to all ones
// RULE5 - pending one means request pending, zero means none
// RULE6 - mask zero enables servicing, mask one blocks it
// RULE7 - pending registers take bit and byte accesses
// RULE8 - mask registers take bit and byte accesses
// RULE9 - pending bit layout fixed; high pending bits 3 to 7 read zero
// RULE10 - mask layout mirrors pending; high mask bits 3 to 7 read one
// RULE11 - twelve requests map to eleven flag pairs; serial rx and csi share
// RULE12 - software keeps watchdog flag zero in watchdog modes
// RULE13 - watchdog mask read in watchdog modes is undefined
// RULE14 - port output level changes set flags; mask first advised
// RULE15 - simultaneous pending requests granted by fixed priority 0 to 10
// RULE16 - offered only when pending, unmasked and globally enabled
// RULE17 - writes to fixed upper high bits are ignored
// RULE18 - hardware set beats a same-cycle software clear
module irmf_flag_bank #(
    parameter NUM_SRC = `IRMF_NUM_SRC,
    parameter IDX_W = `IRMF_IDX_W
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // core register access
    input wire [`IRMF_ADDR_W-1:0] busAddr,
    input wire busWrEn,
    input wire busRdEn,
    input wire busBitOp,
    input wire [2:0] busBitSel,
    input wire [7:0] busWrData,
    output reg [7:0] busRdData,
    // request sources, one-cycle pulses
    input wire watchdog_request,
    input wire pin0_request,
    input wire pin1_request,
    input wire timer_d_match_request,
    input wire timer0_ch0_request,
    input wire timer0_ch1_request,
    input wire timer5_match_request,
    input wire serial_rx_done_request,
    input wire clocked_serial_done_request,
    input wire serial_tx_done_request,
    input wire voltage_detect_request,
    input wire nv_write_done_request,
    // core status
    input wire global_irq_enable,
    input wire watchdogResetMode,
    // offer and acknowledge
    output reg offerValid,
    output reg [IDX_W-1:0] offerIndex,
    input wire ackValid,
    input wire [IDX_W-1:0] ackIndex
);

    // ---------------------------------------------------------------
    // flag storage
    // ---------------------------------------------------------------
    reg [NUM_SRC-1:0] pending;
    reg [NUM_SRC-1:0] mask;
    wire [NUM_SRC-1:0] next_pending;
    wire [NUM_SRC-1:0] next_mask;
    wire [NUM_SRC-1:0] hwSet;
    wire [NUM_SRC-1:0] ready;
    wire pickAny;
    wire [IDX_W-1:0] pickIndex;

    // ---------------------------------------------------------------
    // request mapping
    // ---------------------------------------------------------------
    assign hwSet[`IRMF_SRC_WDT] = watchdog_request; // see RULE11
    assign hwSet[`IRMF_SRC_PIN0] = pin0_request; // see RULE14
    assign hwSet[`IRMF_SRC_PIN1] = pin1_request;
    assign hwSet[`IRMF_SRC_TMD] = timer_d_match_request;
    assign hwSet[`IRMF_SRC_T0C0] = timer0_ch0_request;
    assign hwSet[`IRMF_SRC_T0C1] = timer0_ch1_request;
    assign hwSet[`IRMF_SRC_TM5] = timer5_match_request;
    // shared flag pair for both serial completions
    assign hwSet[`IRMF_SRC_SRX] = serial_rx_done_request |
                                  clocked_serial_done_request; // see RULE11
    assign hwSet[`IRMF_SRC_STX] = serial_tx_done_request;
    assign hwSet[`IRMF_SRC_LVD] = voltage_detect_request;
    assign hwSet[`IRMF_SRC_NVW] = nv_write_done_request;

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    wire [7:0] laneSel;
    wire wrPendLow;
    wire wrPendHigh;
    wire wrMaskLow;
    wire wrMaskHigh;

    // bit access touches one lane, byte access all eight
    assign laneSel = busBitOp ? (`IRMF_BYTE_ONE << busBitSel) :
                     `IRMF_BYTE_ALL; // see RULE7 see RULE8
    assign wrPendLow = busWrEn && (busAddr == `IRMF_PEND_LOW_ADDR);
    assign wrPendHigh = busWrEn && (busAddr == `IRMF_PEND_HIGH_ADDR);
    assign wrMaskLow = busWrEn && (busAddr == `IRMF_MASK_LOW_ADDR);
    assign wrMaskHigh = busWrEn && (busAddr == `IRMF_MASK_HIGH_ADDR);

    // ---------------------------------------------------------------
    // per-source next state
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g = g + 1) begin : src
            localparam LANE = g % 8;
            localparam [IDX_W-1:0] SRC_ID = g;
            wire inHigh;
            wire swPend;
            wire swMask;
            wire ackHit;
            wire afterSw;
            assign inHigh = (g >= 8);
            // bits above the source count simply have no flip-flop
            assign swPend = laneSel[LANE] &&
                            (inHigh ? wrPendHigh : wrPendLow);
            assign swMask = laneSel[LANE] &&
                            (inHigh ? wrMaskHigh : wrMaskLow);
            assign ackHit = ackValid &&
                            (ackIndex == SRC_ID); // see RULE2
            assign afterSw = swPend ? busWrData[LANE] : pending[g];
            // hardware set wins over any clear
            assign next_pending[g] = (afterSw & ~ackHit) |
                                     hwSet[g]; // see RULE1 see RULE18
            assign next_mask[g] = swMask ? busWrData[LANE] : mask[g];
            // offer condition
            assign ready[g] = pending[g] & ~mask[g] &
                              global_irq_enable; // see RULE16 see RULE6
        end
    endgenerate

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pending <= {NUM_SRC{1'b0}}; // see RULE3
            mask <= {NUM_SRC{1'b1}}; // see RULE4
        end else begin
            pending <= next_pending; // see RULE5
            mask <= next_mask;
        end
    end

    // ---------------------------------------------------------------
    // priority and offer
    // ---------------------------------------------------------------
    irmf_priority_pick #(
        .N(NUM_SRC),
        .IW(IDX_W)
    ) picker (
        .ready(ready),
        .any(pickAny),
        .index(pickIndex)
    );

    // every offer is dropped for the one cycle after an acknowledge
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            offerValid <= 1'b0;
            offerIndex <= {IDX_W{1'b0}};
        end else begin
            offerValid <= pickAny && !ackValid; // see RULE15
            offerIndex <= pickIndex;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    reg [7:0] next_rdData;
    wire [7:0] pendLowView;
    wire [7:0] maskLowView;

    assign pendLowView = pending[7:0];
    // watchdog mask bit not meaningful in watchdog reset modes
    assign maskLowView = {mask[7:1], watchdogResetMode ?
                          `IRMF_WDT_MASK_UNDEF : mask[0]}; // see RULE13

    always @* begin
        if (busAddr == `IRMF_PEND_LOW_ADDR) begin
            next_rdData = pendLowView; // see RULE9
        end else if (busAddr == `IRMF_PEND_HIGH_ADDR) begin
            next_rdData = {`IRMF_PEND_HIGH_FIXED,
                           pending[NUM_SRC-1:8]}; // see RULE9 see RULE17
        end else if (busAddr == `IRMF_MASK_LOW_ADDR) begin
            next_rdData = maskLowView; // see RULE10
        end else if (busAddr == `IRMF_MASK_HIGH_ADDR) begin
            next_rdData = {`IRMF_MASK_HIGH_FIXED,
                           mask[NUM_SRC-1:8]}; // see RULE10 see RULE17
        end else begin
            next_rdData = `IRMF_UNMAPPED_READ;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            busRdData <= `IRMF_UNMAPPED_READ;
        end else if (busRdEn) begin
            busRdData <= next_rdData;
        end
    end

endmodule

// ---- test/irmf_flag_bank_chk.sv ----
// assertions on the flag bank ports
`timescale 1ns/100ps
module irmf_flag_bank_chk (
    // clock and reset
    input logic clk,
    input logic reset,
    // register access
    input logic [15:0] busAddr,
    input logic busRdEn,
    input logic [7:0] busRdData,
    // offer side
    input logic global_irq_enable,
    input logic offerValid,
    input logic [3:0] offerIndex,
    input logic ackValid
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (reset);
    sequence ack_s;
        ackValid ##1 !offerValid;
    endsequence
    sequence rd_s(a);
        busRdEn && busAddr == a;
    endsequence
    AST_ACK_DROP: assert property (ackValid |-> ack_s)
        else $error("offer stays after acknowledge");
    AST_HI_PEND: assert property (
        rd_s(16'hffe1) |=> busRdData[7:3] == 5'h00)
        else $error("upper pending bits not zero");
    AST_HI_MASK: assert property (
        rd_s(16'hffe5) |=> busRdData[7:3] == 5'h1f)
        else $error("upper mask bits not one");
    AST_UNMAPPED: assert property (busRdEn && !(busAddr inside
        {16'hffe0, 16'hffe1, 16'hffe4, 16'hffe5}) |=> busRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!busRdEn |=> $stable(busRdData))
        else $error("read data moved");
    AST_OFF_IE: assert property (
        offerValid |-> $past(global_irq_enable))
        else $error("offer without enable");
    AST_NO_IE: assert property (
        !global_irq_enable [*2] |-> !offerValid)
        else $error("offer while disabled");
    AST_IDX: assert property (offerValid |-> offerIndex <= 4'd10)
        else $error("offer index out of range");
    AST_RST: assert property ($fell(reset) |-> !offerValid)
        else $error("offer right after reset");
endmodule

// ---- test/irmf_core_model.sv ----
// core model that acknowledges offered requests after a delay
`timescale 1ns/100ps
module irmf_core_model (
    // clock and reset
    input logic clk,
    input logic reset,
    // offer in and delay
    input logic offerValid,
    input logic [3:0] offerIndex,
    input int dly,
    // acknowledge out
    output logic ackValid,
    output logic [3:0] ackIndex
);
    int cnt;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            ackValid <= 1'b0;
            ackIndex <= 4'h0;
        end else if (offerValid && !ackValid && cnt >= dly) begin
            cnt <= 0;
            ackValid <= 1'b1;
            ackIndex <= offerIndex;
        end else begin
            cnt <= offerValid ? cnt + 1 : 0;
            ackValid <= 1'b0;
            // index is meaningless between acknowledges
            ackIndex <= ~ackIndex;
        end
    end
endmodule

// ---- test/tb_top.sv ----
// top bench: reference flag model against the flag bank
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] busAddr = 16'h0000;
    logic busWrEn = 1'b0;
    logic busRdEn = 1'b0;
    logic busBitOp = 1'b0;
    logic [2:0] busBitSel = 3'h0;
    logic [7:0] busWrData = 8'h00;
    logic [11:0] req = 12'h000;
    logic [11:0] rq = 12'h000;
    logic ie = 1'b0;
    logic wdm = 1'b0;
    logic [7:0] busRdData;
    logic offerValid, ackValid;
    logic [3:0] offerIndex, ackIndex;
    logic [15:0] a;
    logic [15:0] rg [2] = '{16'h0000, 16'hffff};
    int n_mismatch = 0;
    int samples_checked = 0;
    int dly = 0;
    int i, j, t, w;
    always #12.5 clk = ~clk;
    irmf_flag_bank dut (
        .clk, .reset, .busAddr, .busWrEn, .busRdEn, .busBitOp,
        .busBitSel, .busWrData, .busRdData,
        .watchdog_request(req[0]), .pin0_request(req[1]),
        .pin1_request(req[2]), .timer_d_match_request(req[3]),
        .timer0_ch0_request(req[4]), .timer0_ch1_request(req[5]),
        .timer5_match_request(req[6]), .serial_rx_done_request(req[7]),
        .clocked_serial_done_request(req[8]),
        .serial_tx_done_request(req[9]),
        .voltage_detect_request(req[10]),
        .nv_write_done_request(req[11]),
        .global_irq_enable(ie), .watchdogResetMode(wdm),
        .offerValid, .offerIndex, .ackValid, .ackIndex
    );
    irmf_core_model core (
        .clk, .reset, .offerValid, .offerIndex, .dly, .ackValid, .ackIndex
    );
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [15:0] ad, logic [7:0] d, logic b, logic [2:0] s);
        logic m;
        m = ad[15:3] == 13'h1ffc && !ad[1];
        @(posedge clk);
        busAddr <= ad;
        busWrData <= d;
        busBitOp <= b;
        busBitSel <= s;
        busWrEn <= 1'b1;
        req <= rq;
        @(posedge clk);
        busWrEn <= 1'b0;
        req <= 12'h000;
        if (m && b) rg[ad[2]][{ad[0], s}] = d[s];
        else if (m) rg[ad[2]][ad[0]*8 +: 8] = d;
        rg[0][10:0] |= {rq[11:9], rq[8] | rq[7], rq[6:0]};
        rq = 12'h000;
    endtask
    task automatic rd(logic [15:0] ad);
        logic [7:0] e;
        @(posedge clk);
        busAddr <= ad;
        busRdEn <= 1'b1;
        @(posedge clk);
        busRdEn <= 1'b0;
        e = rg[ad[2]][ad[0]*8 +: 8];
        if (ad[0]) e = ad[2] ? e | 8'hf8 : e & 8'h07;
        if (ad == 16'hffe4 && wdm) e[0] = 1'b0;
        if (ad[15:3] != 13'h1ffc || ad[1]) e = 8'h00;
        #1 chk("busRdData", e, busRdData);
    endtask
    always @(posedge clk) begin : ack_ref
        int k;
        k = 0;
        if (ackValid && !reset) begin
            w = 15;
            for (k = 10; k >= 0; k--) if (rg[0][k] && !rg[1][k]) w = k;
            chk("ackIndex", 8'(w), {4'h0, ackIndex});
            rg[0][ackIndex] = 1'b0;
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------------------
    // main sequence
    // ----------------------------------------------------
    initial begin
        void'($urandom(32'hda814748));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 6; i++) rd(16'hffe0 + 16'(i));
        $display("test reset values done");
        for (i = 0; i < 24; i++) begin
            a = 16'hffe0 + 16'($urandom % 6);
            wr(a, 8'($urandom), 1'($urandom), 3'($urandom));
            rd(a);
        end
        $display("test register access done");
        for (i = 0; i < 6; i++) begin
            rq = 12'($urandom);
            wr(16'h0000, 8'h00, 1'b0, 3'h0);
            rd(16'hffe0);
            rd(16'hffe1);
        end
        rq = 12'h002;
        wr(16'hffe0, 8'h00, 1'b0, 3'h0);
        rd(16'hffe0);
        @(posedge clk);
        wdm <= 1'b1; // no watchdog request meanwhile
        rd(16'hffe4);
        @(posedge clk);
        wdm <= 1'b0;
        $display("test requests done");
        for (t = 0; t < 5; t++) begin
            dly = $urandom % 4;
            wr(16'hffe4, 8'($urandom), 1'b0, 3'h0);
            wr(16'hffe5, 8'($urandom), 1'b0, 3'h0);
            rq = 12'($urandom);
            wr(16'h0000, 8'h00, 1'b0, 3'h0);
            repeat (3) @(posedge clk);
            #1 chk("offerValid", 8'h00, {7'h0, offerValid});
            ie <= 1'b1;
            for (j = 0; j < 300 && |(rg[0][10:0] & ~rg[1][10:0]); j++)
                @(posedge clk);
            if (j == 300) begin
                n_mismatch++;
                complete_run();
            end
            repeat (4) @(posedge clk);
            ie <= 1'b0;
            rd(16'hffe0);
            rd(16'hffe1);
        end
        $display("test offers done");
        complete_run();
    end
endmodule
bind irmf_flag_bank irmf_flag_bank_chk u_chk (
    .clk, .reset, .busAddr, .busRdEn, .busRdData, .global_irq_enable,
    .offerValid, .offerIndex, .ackValid
);
